// ==== rtl/ude_pkg.sv ====
// constants and types shared by the descriptor source
package ude_pkg;

  // ----------------------------------------
  // endpoint descriptor contents
  // ----------------------------------------
  localparam logic [7:0] UDE_EP_LEN = 8'h07;
  localparam logic [7:0] UDE_EP_TYPE = 8'h05;
  localparam logic [7:0] UDE_EP2_ADDR = 8'h02;
  localparam logic [7:0] UDE_EP3_ADDR = 8'h83;
  localparam logic [7:0] UDE_EP2_ATTR = 8'h02;
  localparam logic [7:0] UDE_EP3_ATTR = 8'h03;
  localparam logic [15:0] UDE_EP2_MPS_FS = 16'h0040;
  localparam logic [15:0] UDE_EP2_MPS_HS = 16'h0200;
  localparam logic [15:0] UDE_EP3_MPS = 16'h0008;
  localparam logic [7:0] UDE_EP3_IVL = 8'h01;
  localparam logic [7:0] UDE_EP2_IVL_RST = 8'h00;
  localparam logic [1:0] UDE_EP2_NUM = 2'h2;
  localparam logic [1:0] UDE_EP3_NUM = 2'h3;

  // ----------------------------------------
  // byte offsets inside a descriptor
  // ----------------------------------------
  localparam logic [5:0] UDE_OFF_LEN = 6'h00;
  localparam logic [5:0] UDE_OFF_TYPE = 6'h01;
  localparam logic [5:0] UDE_OFF_ADDR = 6'h02;
  localparam logic [5:0] UDE_OFF_ATTR = 6'h03;
  localparam logic [5:0] UDE_OFF_MPS_LO = 6'h04;
  localparam logic [5:0] UDE_OFF_MPS_HI = 6'h05;
  localparam logic [5:0] UDE_OFF_IVL = 6'h06;
  localparam logic [5:0] UDE_OFF_TXT = 6'h02;

  // ----------------------------------------
  // string descriptor contents
  // ----------------------------------------
  localparam logic [7:0] UDE_STR_TYPE = 8'h03;
  localparam logic [7:0] UDE_STR0_LEN = 8'h04;
  localparam logic [15:0] UDE_LANGID = 16'h0409;
  localparam logic [7:0] UDE_DEF_S1_LEN = 8'h04;
  localparam logic [15:0] UDE_DEF_S1_CODE = 16'h0020;
  localparam logic [7:0] UDE_DEF_S2_LEN = 8'h10;
  // byte n of the text sits at bits 8n+7..8n
  localparam logic [111:0] UDE_DEF_S2_TXT = 112'h0068_0074_0045_0020_0042_0053_0055;
  localparam logic [7:0] UDE_DEF_S3_LEN = 8'h04;
  localparam logic [15:0] UDE_DEF_S3_CODE = 16'h0031;

  // ----------------------------------------
  // counts and reset values
  // ----------------------------------------
  localparam logic [1:0] UDE_SETTLE_CYCLES = 2'h3;
  localparam logic [2:0] UDE_STAT_LAST = 3'h7;
  localparam logic [7:0] UDE_STR_LEN_RST = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic {
    UDE_KIND_EP = 1'b0,
    UDE_KIND_STR = 1'b1
  } ude_kind_t;

  typedef enum logic [1:0] {
    UDE_ST_SETTLE = 2'b00,
    UDE_ST_DETECT = 2'b01,
    UDE_ST_LOAD = 2'b11,
    UDE_ST_READY = 2'b10
  } ude_state_t;

endpackage

// ==== rtl/ude_str_mem.sv ====
// byte store for the three text strings loaded from the eeprom
`timescale 1ns/1ps
module ude_str_mem
(
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [7:0] rdata;
  } ude_mem_reg_t;

  logic [7:0] mem [0:255];
  ude_mem_reg_t r;
  ude_mem_reg_t next_r;

  assign rdata = r.rdata;

  always_comb
  begin
    next_r = r;
    next_r.rdata = mem[raddr];
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

endmodule // ude_str_mem

// ==== rtl/ude_desc.sv ====
// endpoint and string descriptor source with interrupt endpoint status answer
//
// What this block does
// - every endpoint descriptor gives length 07H then type 05H
// - endpoint address byte: bulk endpoint 02H, notification endpoint 83H
// - attributes byte: endpoint 2 is bulk 02H, endpoint 3 interrupt 03H
// - bulk endpoint max packet 0040H at full speed, 0200H at high speed
// - interrupt endpoint max packet size is 0008H
// - interrupt endpoint polling interval is 01H ms, legal range 1 to 255
// - bulk endpoint interval resets to 00H, replaced by eeprom value when given
// - string 0 gives length 04H, type 03H, language 0409H
// - with eeprom, strings 1-3 take length and text from it, type fixed 03H
// - without eeprom, strings 1 and 3 are length 04H with codes 0020H, 0031H
// - interrupt endpoint poll outside a burst: nak when nothing pending, else eight status bytes
`timescale 1ns/1ps
module ude_desc
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // eeprom presence pin and link speed
  input wire logic eeprom_present,
  input wire logic high_speed,
  // eeprom loader
  input wire logic ee_wr,
  input wire logic [1:0] ee_str,
  input wire logic [5:0] ee_off,
  input wire logic [7:0] ee_data,
  input wire logic ee_ivl_wr,
  input wire logic [7:0] ee_ivl,
  input wire logic ee_done,
  // descriptor byte request
  input wire logic req,
  input wire ude_pkg::ude_kind_t req_kind,
  input wire logic [1:0] req_index,
  input wire logic [5:0] req_offset,
  // descriptor byte answer
  output logic desc_ready,
  output logic src_eeprom,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [7:0] rsp_len,
  output logic rsp_err,
  // interrupt endpoint
  input wire logic ep3_poll,
  input wire logic irq_pending,
  input wire logic [63:0] status_bytes,
  output logic ep3_nak,
  output logic ep3_valid,
  output logic [7:0] ep3_data,
  output logic ep3_last
);
  import ude_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    ude_state_t st;
    logic [1:0] cnt;
    logic present;
    logic ready;
    logic [7:0] ep2_ivl;
    logic [2:0][7:0] slen;
    logic s1_valid;
    logic s1_use_mem;
    logic [7:0] s1_byte;
    logic [7:0] s1_len;
    logic s1_err;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] rsp_len;
    logic rsp_err;
    logic ep3_busy;
    logic [2:0] ep3_cnt;
    logic [63:0] ep3_snap;
    logic ep3_nak;
    logic ep3_valid;
    logic [7:0] ep3_data;
    logic ep3_last;
  } ude_reg_t;

  ude_reg_t r;
  ude_reg_t next_r;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_raddr;
  logic [1:0] mem_rstr;
  logic [1:0] mem_wstr;

  // ----------------------------------------
  // eeprom string store
  // ----------------------------------------
  // strings 1..3 map to banks 0..2 of 64 bytes
  assign mem_wstr = ee_str - 2'h1;
  assign mem_rstr = req_index - 2'h1;
  assign mem_we = ee_wr && (r.st == UDE_ST_LOAD) && (ee_str != 2'h0);
  assign mem_waddr = {mem_wstr, ee_off};
  assign mem_raddr = {mem_rstr, req_offset};

  ude_str_mem u_mem
  (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(ee_data),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign desc_ready = r.ready;
  assign src_eeprom = r.present;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_len = r.rsp_len;
  assign rsp_err = r.rsp_err;
  assign ep3_nak = r.ep3_nak;
  assign ep3_valid = r.ep3_valid;
  assign ep3_data = r.ep3_data;
  assign ep3_last = r.ep3_last;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [15:0] mps;
    logic [7:0] len;
    logic [7:0] byt;
    logic err;
    logic use_mem;
    mps = UDE_EP3_MPS;
    len = 8'h00;
    byt = 8'h00;
    err = 1'b0;
    use_mem = 1'b0;
    next_r = r;

    // presence pin synchroniser
    next_r.sync1 = eeprom_present;
    next_r.sync2 = r.sync1;

    // start-up sequence: settle, sample presence once, load, serve
    case (r.st)
      UDE_ST_SETTLE:
      begin
        next_r.cnt = r.cnt + 2'h1;
        if (r.cnt == UDE_SETTLE_CYCLES)
        begin
          next_r.st = UDE_ST_DETECT;
        end
      end
      UDE_ST_DETECT:
      begin
        next_r.present = r.sync2;
        next_r.st = r.sync2 ? UDE_ST_LOAD : UDE_ST_READY;
      end
      UDE_ST_LOAD:
      begin
        if (ee_wr && (ee_str != 2'h0) && (ee_off == UDE_OFF_LEN))
        begin
          next_r.slen[mem_wstr] = ee_data;
        end
        if (ee_ivl_wr)
        begin
          next_r.ep2_ivl = ee_ivl;
        end
        if (ee_done)
        begin
          next_r.st = UDE_ST_READY;
        end
      end
      UDE_ST_READY:
      begin
        next_r.st = UDE_ST_READY;
      end
      default:
      begin
        next_r.st = UDE_ST_SETTLE;
      end
    endcase
    next_r.ready = (next_r.st == UDE_ST_READY);

    // descriptor byte lookup, stage one
    if (req_kind == UDE_KIND_EP)
    begin
      len = UDE_EP_LEN;
      if (req_index == UDE_EP2_NUM)
      begin
        mps = high_speed ? UDE_EP2_MPS_HS : UDE_EP2_MPS_FS;
      end
      else
      begin
        mps = UDE_EP3_MPS;
      end
      if ((req_index != UDE_EP2_NUM) && (req_index != UDE_EP3_NUM))
      begin
        err = 1'b1;
      end
      if (req_offset == UDE_OFF_LEN)
      begin
        byt = UDE_EP_LEN;
      end
      else if (req_offset == UDE_OFF_TYPE)
      begin
        byt = UDE_EP_TYPE;
      end
      else if (req_offset == UDE_OFF_ADDR)
      begin
        byt = (req_index == UDE_EP2_NUM) ? UDE_EP2_ADDR : UDE_EP3_ADDR;
      end
      else if (req_offset == UDE_OFF_ATTR)
      begin
        byt = (req_index == UDE_EP2_NUM) ? UDE_EP2_ATTR : UDE_EP3_ATTR;
      end
      else if (req_offset == UDE_OFF_MPS_LO)
      begin
        byt = mps[7:0];
      end
      else if (req_offset == UDE_OFF_MPS_HI)
      begin
        byt = mps[15:8];
      end
      else if (req_offset == UDE_OFF_IVL)
      begin
        byt = (req_index == UDE_EP2_NUM) ? r.ep2_ivl : UDE_EP3_IVL;
      end
    end
    else if (req_index == 2'h0)
    begin
      len = UDE_STR0_LEN;
      if (req_offset == UDE_OFF_LEN)
      begin
        byt = UDE_STR0_LEN;
      end
      else if (req_offset == UDE_OFF_TYPE)
      begin
        byt = UDE_STR_TYPE;
      end
      else if (req_offset == UDE_OFF_TXT)
      begin
        byt = UDE_LANGID[7:0];
      end
      else
      begin
        byt = UDE_LANGID[15:8];
      end
    end
    else if (r.present)
    begin
      len = r.slen[mem_rstr];
      if (req_offset == UDE_OFF_LEN)
      begin
        byt = len;
      end
      else if (req_offset == UDE_OFF_TYPE)
      begin
        byt = UDE_STR_TYPE;
      end
      else
      begin
        use_mem = 1'b1;
      end
    end
    else
    begin
      if (req_index == 2'h2)
      begin
        len = UDE_DEF_S2_LEN;
        byt = UDE_DEF_S2_TXT[{req_offset[3:0] - 4'h2, 3'h0} +: 8];
      end
      else if (req_index == 2'h1)
      begin
        len = UDE_DEF_S1_LEN;
        byt = req_offset[0] ? UDE_DEF_S1_CODE[15:8] : UDE_DEF_S1_CODE[7:0];
      end
      else
      begin
        len = UDE_DEF_S3_LEN;
        byt = req_offset[0] ? UDE_DEF_S3_CODE[15:8] : UDE_DEF_S3_CODE[7:0];
      end
      if (req_offset == UDE_OFF_LEN)
      begin
        byt = len;
      end
      else if (req_offset == UDE_OFF_TYPE)
      begin
        byt = UDE_STR_TYPE;
      end
    end
    // bytes past the end read as zero
    if ({2'b00, req_offset} >= len)
    begin
      byt = 8'h00;
      use_mem = 1'b0;
    end

    next_r.s1_valid = req && r.ready;
    next_r.s1_use_mem = use_mem;
    next_r.s1_byte = byt;
    next_r.s1_len = len;
    next_r.s1_err = err;

    // stage two, picks the stored text when needed
    next_r.rsp_valid = r.s1_valid;
    next_r.rsp_data = r.s1_use_mem ? mem_rdata : r.s1_byte;
    next_r.rsp_len = r.s1_len;
    next_r.rsp_err = r.s1_err;

    // interrupt endpoint poll answer
    next_r.ep3_nak = 1'b0;
    next_r.ep3_valid = 1'b0;
    next_r.ep3_last = 1'b0;
    if (r.ep3_busy)
    begin
      next_r.ep3_valid = 1'b1;
      next_r.ep3_data = r.ep3_snap[{r.ep3_cnt, 3'h0} +: 8];
      next_r.ep3_last = (r.ep3_cnt == UDE_STAT_LAST);
      next_r.ep3_cnt = r.ep3_cnt + 3'h1;
      if (r.ep3_cnt == UDE_STAT_LAST)
      begin
        next_r.ep3_busy = 1'b0;
      end
    end
    else if (ep3_poll)
    begin
      if (irq_pending)
      begin
        next_r.ep3_busy = 1'b1;
        next_r.ep3_cnt = 3'h0;
        next_r.ep3_snap = status_bytes;
      end
      else
      begin
        next_r.ep3_nak = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.st <= UDE_ST_SETTLE;
      r.ep2_ivl <= UDE_EP2_IVL_RST;
      r.slen <= {3{UDE_STR_LEN_RST}};
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule // ude_desc

// ==== verification/ude_host.sv ====
// host model issuing one-cycle descriptor byte requests
`timescale 1ns/1ps
module ude_host
(
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire ude_pkg::ude_kind_t kind,
  input wire logic [1:0] idx,
  input wire logic [5:0] off,
  // request to the block
  output logic req = 1'b0,
  output ude_pkg::ude_kind_t req_kind = ude_pkg::UDE_KIND_EP,
  output logic [1:0] req_index = 2'h0,
  output logic [5:0] req_offset = 6'h00
);
  import ude_pkg::*;
  // idle address lines toggle so a stale value never looks valid
  always @(posedge clk)
  begin
    req <= go;
    req_kind <= go ? kind : ude_kind_t'(~req_kind);
    req_index <= go ? idx : ~req_index;
    req_offset <= go ? off : ~req_offset;
  end
endmodule // ude_host

// ==== verification/ude_desc_monitor.sv ====
// port assertions for the descriptor source
`timescale 1ns/1ps
module ude_desc_chk
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic high_speed,
  input wire logic req,
  input wire ude_pkg::ude_kind_t req_kind,
  input wire logic [1:0] req_index,
  input wire logic [5:0] req_offset,
  input wire logic desc_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic [7:0] rsp_len,
  input wire logic rsp_err,
  input wire logic ep3_poll,
  input wire logic irq_pending,
  input wire logic ep3_nak,
  input wire logic ep3_valid,
  input wire logic ep3_last
);
  import ude_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // request fields delayed to line up with the answer
  logic [9:0] d1;
  logic [9:0] d2;
  always_ff @(posedge clk)
  begin
    d1 <= {req_kind, req_index, req_offset, high_speed};
    d2 <= d1;
  end
  wire ep = rsp_valid && !d2[9];
  wire st = rsp_valid && d2[9];
  wire [1:0] ix = d2[8:7];
  wire [5:0] o = d2[6:1];
  ep_head_a: assert property (ep && o < 6'h02 |-> rsp_len == 8'h07 && rsp_data == (o[0] ? 8'h05 : 8'h07))
    else $error("endpoint header wrong");
  ep_addr_a: assert property (ep && o == 6'h02 |-> rsp_data == (ix == 2'h2 ? 8'h02 : 8'h83))
    else $error("endpoint address wrong");
  ep_attr_a: assert property (ep && o == 6'h03 |-> rsp_data == (ix == 2'h2 ? 8'h02 : 8'h03))
    else $error("endpoint attributes wrong");
  ep2_mps_a: assert property (ep && ix == 2'h2 && o[5:1] == 5'h02 |->
    rsp_data == (o[0] ? {6'h00, d2[0], 1'b0} : (d2[0] ? 8'h00 : 8'h40))) else $error("bulk packet size wrong");
  ep3_mps_a: assert property (ep && ix == 2'h3 && o[5:1] == 5'h02 |-> rsp_data == (o[0] ? 8'h00 : 8'h08))
    else $error("interrupt packet size wrong");
  ep3_ivl_a: assert property (ep && ix == 2'h3 && o == 6'h06 |-> rsp_data == 8'h01)
    else $error("interrupt interval wrong");
  str_zero_a: assert property (st && ix == 2'h0 && o < 6'h04 |->
    rsp_data == (o == 6'h01 ? 8'h03 : o == 6'h02 ? 8'h09 : 8'h04)) else $error("language string wrong");
  str_type_a: assert property (st && o == 6'h01 && rsp_len > 8'h01 |-> rsp_data == 8'h03)
    else $error("string type wrong");
  rsp_lat_a: assert property (req && desc_ready |-> ##2 rsp_valid)
    else $error("answer not two cycles after request");
  poll_nak_a: assert property (ep3_nak |-> $past(ep3_poll && !irq_pending) && !ep3_valid)
    else $error("nak without idle poll");
  burst_len_a: assert property ($rose(ep3_valid) |-> ep3_valid [*8] ##1 !ep3_valid)
    else $error("status burst not eight bytes");
  burst_cause_a: assert property ($rose(ep3_valid) |-> $past(ep3_poll && irq_pending, 2))
    else $error("status burst without pending poll");
  ep_err_a: assert property (rsp_valid |-> rsp_err == (ep && ix != 2'h2 && ix != 2'h3))
    else $error("endpoint index error flag wrong");
  burst_last_a: assert property ($rose(ep3_valid) |-> !ep3_last [*7] ##1 ep3_last ##1 !ep3_last)
    else $error("last status byte flag misplaced");
endmodule // ude_desc_chk

bind ude_desc ude_desc_chk chk (.clk(clk), .rstn(rstn), .high_speed(high_speed), .req(req), .req_kind(req_kind),
  .req_index(req_index), .req_offset(req_offset), .desc_ready(desc_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_len(rsp_len), .rsp_err(rsp_err), .ep3_poll(ep3_poll), .irq_pending(irq_pending),
  .ep3_nak(ep3_nak), .ep3_valid(ep3_valid), .ep3_last(ep3_last));

// ==== verification/testbench.sv ====
// self-checking bench for the descriptor source
`timescale 1ns/1ps
module testbench;
  import ude_pkg::*;
  logic clk = 0, rstn = 0, eep = 0, hs = 0, go = 0, ee_wr = 0, ee_ivl_wr = 0, ee_done = 0, poll = 0, pend = 0;
  logic [1:0] gi = 0, ee_str = 0, req_index;
  logic [5:0] goff = 0, ee_off = 0, req_offset;
  logic [7:0] ee_data = 0, ee_ivl = 0, rd, rl, ed;
  logic [63:0] stat = 0;
  ude_kind_t gk = UDE_KIND_EP, req_kind;
  logic req, rdy, src, rv, err, nak, ev, last;
  logic [7:0] exp_q[$];
  logic [127:0] st[4];
  int miscompares = 0, comparisons = 0, n, o;

  initial forever #5 clk = ~clk;

  ude_host host (.clk(clk), .go(go), .kind(gk), .idx(gi), .off(goff), .req(req), .req_kind(req_kind),
    .req_index(req_index), .req_offset(req_offset));
  ude_desc dut (.clk(clk), .rstn(rstn), .eeprom_present(eep), .high_speed(hs), .ee_wr(ee_wr), .ee_str(ee_str),
    .ee_off(ee_off), .ee_data(ee_data), .ee_ivl_wr(ee_ivl_wr), .ee_ivl(ee_ivl), .ee_done(ee_done), .req(req),
    .req_kind(req_kind), .req_index(req_index), .req_offset(req_offset), .desc_ready(rdy), .src_eeprom(src),
    .rsp_valid(rv), .rsp_data(rd), .rsp_len(rl), .rsp_err(err), .ep3_poll(poll), .irq_pending(pend),
    .status_bytes(stat), .ep3_nak(nak), .ep3_valid(ev), .ep3_data(ed), .ep3_last(last));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic ask(input ude_kind_t k, input logic [1:0] i, input int off, input logic [7:0] want);
    @(posedge clk);
    #1;
    go = 1;
    gk = k;
    gi = i;
    goff = 6'(off);
    exp_q.push_back(want);
  endtask

  // release the request, wait for ready and every pending answer
  task automatic settle;
    @(posedge clk);
    #1;
    go = 0;
    for (n = 0; n < 40 && (exp_q.size() > 0 || rdy !== 1'b1); n++)
      @(posedge clk);
    if (n == 40)
    begin
      miscompares++;
      stop_test;
    end
    #1;
  endtask

  task automatic do_reset(input logic e);
    rstn = 0;
    eep = e;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1;
  endtask

  task automatic poll_once;
    poll = 1;
    @(posedge clk);
    #1;
    poll = 0;
  endtask

  always @(negedge clk)
    if (rv === 1'b1 || ev === 1'b1)
      check(rv ? rd : ed, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);

  initial
  begin
    void'($urandom(32'h4297));
    st[0] = 128'h0409_0304;
    st[1] = 128'h0020_0304;
    st[2] = 128'h0068_0074_0045_0020_0042_0053_0055_0310;
    st[3] = 128'h0031_0304;
    do_reset(1'b0);
    settle;
    check(src, 8'h00);
    // endpoints 2, 3 and an unknown index, back to back
    for (o = 0; o < 24; o++)
      ask(UDE_KIND_EP, o < 8 ? 2'h2 : o < 16 ? 2'h3 : 2'h0, o % 8,
        8'((o < 8 ? 64'h0000_0040_0202_0507 : 64'h0001_0008_0383_0507) >> 8 * (o % 8)));
    for (o = 0; o < 64; o++)
      ask(UDE_KIND_STR, 2'(o / 16), o % 16, 8'(st[o / 16] >> 8 * (o % 16)));
    settle;
    hs = 1;
    ask(UDE_KIND_EP, 2'h2, 4, 8'h00);
    ask(UDE_KIND_EP, 2'h2, 5, 8'h02);
    settle;
    poll_once;
    check(nak, 8'h01);
    @(posedge clk);
    #1;
    pend = 1;
    stat = {$urandom, $urandom};
    for (o = 0; o < 8; o++)
      exp_q.push_back(stat[8 * o +: 8]);
    poll_once;
    repeat (2) @(posedge clk);
    #1;
    // a poll inside the running burst must not add bytes
    poll_once;
    pend = 0;
    settle;
    do_reset(1'b1);
    repeat (10) @(posedge clk);
    #1;
    ee_wr = 1;
    ee_str = 2'h1;
    for (o = 0; o < 6; o++)
    begin
      ee_off = 6'(o);
      ee_data = o == 0 ? 8'h06 : 8'($urandom);
      st[1][8 * o +: 8] = o == 1 ? 8'h03 : ee_data;
      @(posedge clk);
      #1;
    end
    ee_wr = 0;
    ee_ivl_wr = 1;
    ee_ivl = 8'($urandom);
    @(posedge clk);
    #1;
    ee_ivl_wr = 0;
    ee_done = 1;
    @(posedge clk);
    #1;
    ee_done = 0;
    settle;
    check(src, 8'h01);
    for (o = 0; o < 8; o++)
      ask(UDE_KIND_STR, 2'h1, o, st[1][8 * o +: 8]);
    ask(UDE_KIND_STR, 2'h2, 0, 8'h00);
    ask(UDE_KIND_EP, 2'h2, 6, ee_ivl);
    ask(UDE_KIND_STR, 2'h0, 2, 8'h09);
    settle;
    stop_test;
  end
endmodule // testbench
